// *** sbd_pkg.sv ***
// Package for the subtract execution datapath: opcode fields, widths and reset values.
// Assumes a 14-bit instruction word and an 8-bit data path.
`default_nettype none
package sbd_pkg;
  localparam int unsigned INSN_W      = 14;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned FADDR_W     = 7;
  localparam int unsigned OPC_MSB     = 13;
  localparam int unsigned LIT_OPC_LSB = 9;
  localparam int unsigned REG_OPC_LSB = 8;
  localparam int unsigned DEST_BIT    = 7;
  localparam int unsigned NIB_W       = 4;
  localparam logic [4:0]  LIT_OPC     = 5'h1E;  // 11 110x
  localparam logic [5:0]  REG_OPC     = 6'h02;  // 00 0010
  localparam logic [7:0]  ACC_RST     = 8'h00;
  localparam logic        FLAG_RST    = 1'b0;
  localparam logic [6:0]  ADDR_RST    = 7'h00;
  localparam logic        PULSE_RST   = 1'b0;

  typedef enum logic [1:0] {
    SBD_OP_NONE,
    SBD_OP_LIT,
    SBD_OP_REG
  } sbd_op_t;
endpackage : sbd_pkg
`default_nettype wire

// *** sbd_regfile_model.sv ***
// Partner: data register file, cell n starts at n
// Write-back lands at the index of the previous enabled cycle
`default_nettype none
module sbd_regfile_model (
  input wire logic       core_clk, clk_en, reg_we,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic     [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [128];
  logic [6:0] wa;
  initial for (int n = 0; n < 128; n++) mem[n] = 8'(n);
  assign reg_rdata = mem[reg_addr];
  always @(posedge core_clk) if (clk_en) begin
    wa <= reg_addr;
    if (reg_we) mem[wa] <= reg_wdata;
  end
endmodule : sbd_regfile_model
`default_nettype wire

// *** sbd_subtract_datapath.sv ***
// Subtract execution datapath: decodes both subtract forms and updates
// accumulator, register write-back and status flags.
// Assumes core_clk is the instruction clock; one instruction per enabled edge;
// reg_rdata is the combinational read of the register at reg_addr.
`default_nettype none

// Overview of operation
// - Literal minus accumulator into accumulator
// - Addressed register minus accumulator, 7-bit index
// - Destination bit picks accumulator or register
// - No borrow sets borrow-inverse; update nibble, zero
// - Equal operands: zero result, flags set
// - Negative: borrow-inverse clear, wrap modulo 256
module sbd_subtract_datapath
  import sbd_pkg::*;
(
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  input  wire logic                       clk_en,
  input  wire logic                       insn_valid,
  input  wire logic [sbd_pkg::INSN_W-1:0] insn,
  input  wire logic [sbd_pkg::DATA_W-1:0] reg_rdata,
  output logic      [sbd_pkg::FADDR_W-1:0] reg_addr,
  output logic      [sbd_pkg::DATA_W-1:0] reg_wdata,
  output logic                            reg_we,
  output logic      [sbd_pkg::DATA_W-1:0] acc,
  output logic                            borrow_inverse_flag,
  output logic                            nibble_borrow_inverse_flag,
  output logic                            zero_flag,
  output logic                            insn_done
);
  import sbd_pkg::*;

  // Decode and operand selection
  sbd_op_t               op;
  logic                  exec;
  logic                  to_reg;
  logic                  fwd_hit;
  logic [DATA_W-1:0]     minuend;
  logic [DATA_W-1:0]     diff;
  logic                  no_borrow;
  logic                  nib_no_borrow;

  // Accumulator
  logic [DATA_W-1:0]     acc_d;
  logic [DATA_W-1:0]     acc_q;

  // Register write-back
  logic [DATA_W-1:0]     wdata_d;
  logic [DATA_W-1:0]     wdata_q;
  logic                  we_d;
  logic                  we_q;
  logic [FADDR_W-1:0]    wb_addr_d;
  logic [FADDR_W-1:0]    wb_addr_q;

  // Status flags
  logic                  c_d;
  logic                  c_q;
  logic                  dc_d;
  logic                  dc_q;
  logic                  z_d;
  logic                  z_q;

  // Completion pulse
  logic                  done_d;
  logic                  done_q;

  // Register index taken straight from the operand field
  assign reg_addr = insn[FADDR_W-1:0];

  always_comb begin
    op = SBD_OP_NONE;
    if (insn_valid) begin
      if (insn[OPC_MSB:LIT_OPC_LSB] == LIT_OPC) begin
        op = SBD_OP_LIT;
      end else if (insn[OPC_MSB:REG_OPC_LSB] == REG_OPC) begin
        op = SBD_OP_REG;
      end
    end
  end

  always_comb begin
    exec   = (op != SBD_OP_NONE);
    to_reg = (op == SBD_OP_REG) && insn[DEST_BIT];
  end

  // Write-back lands one cycle late; forward it to a back-to-back read
  always_comb begin
    fwd_hit = we_q && (wb_addr_q == reg_addr);
    if (op == SBD_OP_LIT) begin
      minuend = insn[DATA_W-1:0];
    end else if (fwd_hit) begin
      minuend = wdata_q;
    end else begin
      minuend = reg_rdata;
    end
  end

  // Whole byte and low nibble each get their own subtract cell instance
  sbd_sub_cell #(.W(DATA_W)) i_byte_sub (
    .minuend    (minuend),
    .subtrahend (acc_q),
    .diff       (diff),
    .no_borrow  (no_borrow)
  );

  sbd_sub_cell #(.W(NIB_W)) i_nib_sub (
    .minuend    (minuend[NIB_W-1:0]),
    .subtrahend (acc_q[NIB_W-1:0]),
    .diff       (),
    .no_borrow  (nib_no_borrow)
  );

  // Accumulator takes the difference unless it goes back to the register
  always_comb begin
    acc_d = acc_q;
    if (exec && !to_reg) begin
      acc_d = diff;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      acc_q <= ACC_RST;
    end else if (clk_en) begin
      acc_q <= acc_d;
    end
  end

  // Write strobe is a one-cycle pulse; index kept for forwarding
  always_comb begin
    wdata_d   = wdata_q;
    we_d      = 1'b0;
    wb_addr_d = wb_addr_q;
    if (exec && to_reg) begin
      wdata_d   = diff;
      we_d      = 1'b1;
      wb_addr_d = reg_addr;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wdata_q   <= ACC_RST;
      we_q      <= PULSE_RST;
      wb_addr_q <= ADDR_RST;
    end else if (clk_en) begin
      wdata_q   <= wdata_d;
      we_q      <= we_d;
      wb_addr_q <= wb_addr_d;
    end
  end

  // Flags follow both destinations
  always_comb begin
    c_d  = c_q;
    dc_d = dc_q;
    z_d  = z_q;
    if (exec) begin
      c_d  = no_borrow;
      dc_d = nib_no_borrow;
      z_d  = (diff == '0);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      c_q  <= FLAG_RST;
      dc_q <= FLAG_RST;
      z_q  <= FLAG_RST;
    end else if (clk_en) begin
      c_q  <= c_d;
      dc_q <= dc_d;
      z_q  <= z_d;
    end
  end

  always_comb begin
    done_d = 1'b0;
    if (exec) begin
      done_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      done_q <= PULSE_RST;
    end else if (clk_en) begin
      done_q <= done_d;
    end
  end

  assign acc                        = acc_q;
  assign reg_wdata                  = wdata_q;
  assign reg_we                     = we_q;
  assign borrow_inverse_flag        = c_q;
  assign nibble_borrow_inverse_flag = dc_q;
  assign zero_flag                  = z_q;
  assign insn_done                  = done_q;
endmodule : sbd_subtract_datapath

// Two's complement subtract: minuend plus inverted subtrahend plus one
module sbd_sub_cell #(
  parameter int unsigned W = 8
) (
  input  wire logic [W-1:0] minuend,
  input  wire logic [W-1:0] subtrahend,
  output logic      [W-1:0] diff,
  output logic              no_borrow
);
  import sbd_pkg::*;

  logic [W:0]               sum;

  // Top bit of the sum is the inverted borrow
  always_comb begin
    sum       = {1'b0, minuend} + {1'b0, ~subtrahend} + {{W{1'b0}}, 1'b1};
    diff      = sum[W-1:0];
    no_borrow = sum[W];
  end
endmodule : sbd_sub_cell
`default_nettype wire

// *** sbd_subtract_datapath_sva.sv ***
// Checker: subtract datapath timing, result and flags
// Bound into the datapath top module
`default_nettype none
module sbd_sva (
  input wire logic        core_clk, rst, clk_en, insn_valid, reg_we,
  input wire logic [13:0] insn,
  input wire logic [7:0]  acc, reg_wdata, reg_rdata,
  input wire logic        borrow_inverse_flag, nibble_borrow_inverse_flag, zero_flag, insn_done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire       go = clk_en && insn_valid;
  wire       lit = go && insn[13:9] == 5'h1E;
  wire       rg = go && insn[13:8] == 6'h02;
  wire [7:0] k = insn[7:0];
  lit_acc_a: assert property (lit |=> acc == $past(k) - $past(acc)) else $error("acc");
  wb_write_a: assert property (rg && insn[7] |=> reg_we && acc == $past(acc)) else $error("we");
  borrow_flag_a: assert property (lit |=> borrow_inverse_flag == ($past(k) >= $past(acc))) else $error("c");
  zero_flag_a: assert property (lit |=> zero_flag == (acc == 8'h00)) else $error("z");
  one_cycle_a: assert property (lit || rg |=> insn_done) else $error("done");
  idle_done_a: assert property (clk_en && !lit && !rg |=> !insn_done) else $error("idle");
  reg_acc_a: assert property (rg && !insn[7] |=> !reg_we) else $error("d0");
  nib_flag_a: assert property (lit |=> nibble_borrow_inverse_flag == ($past(k[3:0]) >= $past(acc[3:0]))) else $error("dc");
  wrap_borrow_a: assert property (lit && k < acc |=> !borrow_inverse_flag) else $error("neg");
  reg_sub_a: assert property (rg && !insn[7] && !reg_we |=> acc == $past(reg_rdata) - $past(acc)) else $error("reg");
  freeze_hold_a: assert property (!clk_en |=> $stable(acc) && $stable(insn_done)) else $error("freeze");
endmodule : sbd_sva
bind sbd_subtract_datapath sbd_sva i_sva (.*);
`default_nettype wire

// *** test_subtract_instruction_datapath.sv ***
// Testbench: literal and register subtracts against a register file model
`default_nettype none
module test_subtract_instruction_datapath;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        clk_en = 1'b1;
  logic        insn_valid = 1'b0;
  logic [13:0] insn = 14'h0000;
  logic [7:0]  ea = 8'h00;
  logic [7:0]  er [128];
  wire [6:0] ra;
  wire [7:0] rd, wd, acc;
  wire we, c, dc, z, done;
  int fail_count = 0, check_count = 0;
  always #5 core_clk = ~core_clk;
  sbd_subtract_datapath i_dut (.core_clk, .rst, .clk_en, .insn_valid, .insn, .reg_rdata(rd), .reg_addr(ra),
    .reg_wdata(wd), .reg_we(we), .acc, .borrow_inverse_flag(c), .nibble_borrow_inverse_flag(dc),
    .zero_flag(z), .insn_done(done));
  sbd_regfile_model i_rf (.core_clk, .clk_en, .reg_we(we), .reg_addr(ra), .reg_wdata(wd), .reg_rdata(rd));
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk
  initial for (int n = 0; n < 128; n++) er[n] = 8'(n);
  // Judges one executed instruction from the accumulator and register images
  task automatic judge(input logic [13:0] i);
    logic [7:0] m;
    logic [7:0] r;
    m = i[13] ? i[7:0] : er[i[6:0]];
    r = m - ea;
    chk("done", done, 8'h01);
    chk("flags", {c, dc, z}, {5'h00, m >= ea, m[3:0] >= ea[3:0], r == 8'h00});
    if (!i[13]) chk("reg_addr", ra, i[6:0]);
    if (!i[13] && i[7]) begin
      chk("reg_we", we, 8'h01);
      chk("reg_wdata", wd, r);
      er[i[6:0]] = r;
    end else begin
      chk("reg_we", we, 8'h00);
      ea = r;
    end
    chk("acc", acc, ea);
  endtask : judge
  task automatic run(input logic [13:0] i);
    @(posedge core_clk);
    insn       <= i;
    insn_valid <= 1'b1;
    @(posedge core_clk);
    insn_valid <= 1'b0;
    #1;
    judge(i);
  endtask : run
  task automatic test_literal;
    run(14'h3C02);
    run(14'h3DFF);
    run(14'h3CFD);
    run(14'h3C05);
    run(14'h3C03);
  endtask : test_literal
  task automatic test_register;
    run(14'h0283);
    run(14'h0203);
  endtask : test_register
  task automatic test_back_to_back;
    @(posedge core_clk);
    insn       <= 14'h0285;
    insn_valid <= 1'b1;
    @(posedge core_clk);
    insn       <= 14'h0205;
    #1;
    judge(14'h0285);
    @(posedge core_clk);
    insn_valid <= 1'b0;
    #1;
    judge(14'h0205);
  endtask : test_back_to_back
  task automatic test_refused;
    @(posedge core_clk);
    insn       <= 14'h3A05;
    insn_valid <= 1'b1;
    @(posedge core_clk);
    insn       <= 14'h3C77;
    clk_en     <= 1'b0;
    #1;
    chk("done_other", done, 8'h00);
    chk("acc_other", acc, ea);
    @(posedge core_clk);
    clk_en     <= 1'b1;
    insn_valid <= 1'b0;
    #1;
    chk("done_frozen", done, 8'h00);
    chk("acc_frozen", acc, ea);
    chk("we_frozen", we, 8'h00);
  endtask : test_refused
  task automatic test_reset;
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    ea = 8'h00;
    #1;
    chk("acc_rst", acc, 8'h00);
    chk("flags_rst", {c, dc, z, we, done}, 8'h00);
    run(14'h3C10);
  endtask : test_reset
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  initial begin
    #3000 fail_count++;
    finish_test;
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    test_literal;
    test_register;
    test_back_to_back;
    test_refused;
    test_reset;
    finish_test;
  end
endmodule : test_subtract_instruction_datapath
`default_nettype wire
